//--- bench/scs_host.sv
/*
  serial master model standing in for the host processor.
  assumes the system clock paces it and the slave syncs all pins itself.
*/
`timescale 1ns/1ns
module scs_host (
  input wire logic clk_sys_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // idle: clock parked high (mode 3), slave deselected
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one frame of nclk clocks, msb first, 160 ns clock period
  // a count below 16 makes a broken frame on purpose
  task automatic xfer(input logic [15:0] w, input int nclk,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    // slave needs three cycles before it sees select
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < nclk; i++) begin
      sclk_out <= 1'b0;
      mosi_out <= w[15-i];
      repeat (8) @(posedge clk_sys_in);
      // miso was launched at the fall, settled by now
      sclk_out <= 1'b1;
      r = {r[14:0], miso_in};
      repeat (8) @(posedge clk_sys_in);
    end
    cs_n_out <= 1'b1;
    // released data line flips so a stale bit is never trusted
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_sys_in);
  endtask
endmodule

//--- bench/tb_top.sv
/*
  self-checking bench for the command and status register group.
  assumes scs_regs with its serial host model; timed commands shortened.
*/
`timescale 1ns/1ns
module tb_top;
  // shortened command times, long enough to fit one word inside
  localparam int WC = 300;
  localparam int SC = 600;
  localparam int EC = 700;
  localparam int VC = 400;
  localparam int FC = 500;
  localparam int LIMIT = 60000;
  logic clk_sys_in, rst_n_in, sclk_in, cs_n_in, mosi_in, miso_out;
  logic miso_oe_out, dio_one_out, dio_one_oe_out, dio_two_out;
  logic dio_two_oe_out, data_ready_in, sample_tick_in, supply_over_in;
  logic supply_under_in, checksum_bad_in, alarm_one_in, alarm_two_in;
  logic buffer_full_in, post_running_in, post_fail_in, flash_fail_in;
  logic standby_out, suspend_out, peak_sum_en_out, peak_axis_en_out;
  logic skip_post_out, self_test_out, ce_in;
  logic [1:0] alarm_claim_in, alarm_level_in, ext_lvl;
  logic [8:0] command_pulse_out, last_pulse;
  logic [9:0] x_offset_trim_out, y_offset_trim_out, z_offset_trim_out;
  logic [15:0] rx, susp_cnt;
  logic [6:0] ra [8];
  logic [15:0] re [8];
  int tn [5];
  int tc [5];
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // wire level: the driving party wins, else the outside level
  wire dio_one_in = dio_one_oe_out ? dio_one_out : ext_lvl[0];
  wire dio_two_in = dio_two_oe_out ? dio_two_out : ext_lvl[1];

  scs_regs #(.WAKE_CYC(26'(WC)), .SWRST_CYC(26'(SC)), .ERASE_CYC(26'(EC)),
    .SAVE_CYC(26'(VC)), .FACTORY_CYC(26'(FC))) DUT (.clk_sys_in,
    .rst_n_in, .ce_in, .sclk_in, .cs_n_in, .mosi_in, .miso_out,
    .miso_oe_out, .dio_one_in, .dio_one_out, .dio_one_oe_out, .dio_two_in,
    .dio_two_out, .dio_two_oe_out, .data_ready_in, .alarm_claim_in,
    .alarm_level_in, .sample_tick_in, .supply_over_in, .supply_under_in,
    .checksum_bad_in, .alarm_one_in, .alarm_two_in, .buffer_full_in,
    .post_running_in, .post_fail_in, .flash_fail_in, .command_pulse_out,
    .standby_out, .suspend_out, .peak_sum_en_out, .peak_axis_en_out,
    .skip_post_out, .self_test_out, .x_offset_trim_out,
    .y_offset_trim_out, .z_offset_trim_out);

  scs_host host (.clk_sys_in, .miso_in(miso_out), .sclk_out(sclk_in),
    .cs_n_out(cs_n_in), .mosi_out(mosi_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // pulse catcher, suspend length counter and hang guard
  always @(posedge clk_sys_in) begin
    if (command_pulse_out !== 9'h000)
      last_pulse <= command_pulse_out;
    if (suspend_out === 1'b1)
      susp_cnt <= susp_cnt + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // byte write word, then a whole register as two bytes
  task wb(input logic [6:0] a, input logic [7:0] b);
    host.xfer({1'b1, a, b}, 16, rx);
  endtask

  task wr(input logic [6:0] a, input logic [15:0] d);
    wb(a, d[7:0]);
    wb(a + 7'h01, d[15:8]);
  endtask

  // read answer arrives during the following word
  task rc(input logic [6:0] a, output logic [15:0] d);
    host.xfer({1'b0, a, 8'h00}, 16, d);
    host.xfer(16'h0000, 16, d);
  endtask

  // one-cycle burst on every sticky event input plus a sample tick
  task ev;
    @(posedge clk_sys_in);
    {alarm_one_in, alarm_two_in, buffer_full_in, post_running_in,
      post_fail_in, flash_fail_in, sample_tick_in} <= 7'h7f;
    @(posedge clk_sys_in);
    {alarm_one_in, alarm_two_in, buffer_full_in, post_running_in,
      post_fail_in, flash_fail_in, sample_tick_in} <= 7'h00;
  endtask

  initial begin
    {data_ready_in, sample_tick_in, supply_over_in, supply_under_in} = '0;
    {checksum_bad_in, alarm_one_in, alarm_two_in, buffer_full_in} = '0;
    {post_running_in, post_fail_in, flash_fail_in} = '0;
    alarm_claim_in = 2'b00;
    alarm_level_in = 2'b00;
    ext_lvl = 2'b00;
    ce_in = 1'b1;
    last_pulse = 9'h000;
    susp_cnt = 16'h0000;
    ra = '{7'h1a, 7'h20, 7'h22, 7'h24, 7'h44, 7'h46, 7'h4a, 7'h10};
    re = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0006, 16'h0, 16'h0};
    tn = '{8, 7, 6, 3, 1};
    tc = '{WC, SC, EC, VC, FC};
    rst_n_in = 1'b0;
    tk(6);
    rst_n_in <= 1'b1;
    tk(4);
    // reset values, command and unmapped places read zero
    for (int i = 0; i < 8; i++) begin
      rc(ra[i], rx);
      chk(rx, re[i]);
    end
    // deselected slave must leave its data line undriven
    chk({15'h0, miso_oe_out}, 16'h0000);
    $display("test reset values done");
    // unused high bits dropped, sign bit kept
    for (int i = 0; i < 3; i++)
      wr(7'h20 + 7'(2 * i), 16'hfe00 + 16'(i));
    for (int i = 0; i < 3; i++) begin
      rc(7'h20 + 7'(2 * i), rx);
      chk(rx, 16'h0200 + 16'(i));
    end
    chk({6'h0, x_offset_trim_out}, 16'h0200);
    chk({6'h0, y_offset_trim_out}, 16'h0201);
    chk({6'h0, z_offset_trim_out}, 16'h0202);
    $display("test offsets done");
    wr(7'h46, 16'hffff);
    rc(7'h46, rx);
    chk(rx, 16'hc307);
    chk({12'h0, peak_sum_en_out, peak_axis_en_out, skip_post_out,
      self_test_out}, 16'h000f);
    wr(7'h46, 16'h0000);
    chk({12'h0, peak_sum_en_out, peak_axis_en_out, skip_post_out,
      self_test_out}, 16'h0000);
    $display("test control bits done");
    // line order: {two oe, two out, one oe, one out}
    wr(7'h44, 16'h0103);
    tk(3);
    chk({12'h0, dio_two_oe_out, dio_two_out, dio_one_oe_out,
      dio_one_out}, 16'h000b);
    alarm_claim_in <= 2'b01;
    data_ready_in <= 1'b1;
    tk(3);
    chk({15'h0, dio_one_out}, 16'h0000);
    re[0:2] = '{16'h000b, 16'h000a, 16'h000e};
    ra[0:2] = '{7'h06, 7'h04, 7'h07};
    for (int i = 0; i < 3; i++) begin
      wb(7'h46, {1'b0, ra[i]});
      tk(3);
      chk({12'h0, dio_two_oe_out, dio_two_out, dio_one_oe_out,
        dio_one_out}, re[i]);
    end
    wb(7'h46, 8'h00);
    alarm_claim_in <= 2'b00;
    wr(7'h44, 16'h0000);
    ext_lvl <= 2'b10;
    tk(4);
    rc(7'h44, rx);
    chk(rx, 16'h0200);
    $display("test lines done");
    checksum_bad_in <= 1'b1;
    supply_over_in <= 1'b1;
    supply_under_in <= 1'b1;
    ev();
    rc(7'h1a, rx);
    chk(rx, 16'h03f7);
    supply_under_in <= 1'b0;
    rc(7'h1a, rx);
    chk(rx, 16'h0040);
    tk(1);
    sample_tick_in <= 1'b1;
    tk(1);
    sample_tick_in <= 1'b0;
    rc(7'h1a, rx);
    chk(rx, 16'h0042);
    checksum_bad_in <= 1'b0;
    supply_over_in <= 1'b0;
    host.xfer(16'hffff, 8, rx);
    rc(7'h1a, rx);
    chk(rx, 16'h0008);
    $display("test status flags done");
    // untimed commands; flag clear runs after fresh events
    ev();
    tn[0:3] = '{0, 4, 5, 2};
    for (int i = 0; i < 4; i++) begin
      last_pulse = 9'h000;
      susp_cnt = 16'h0000;
      wb(7'h4a, 8'h01 << tn[i]);
      chk({7'h0, last_pulse}, 16'h0001 << tn[i]);
      chk(susp_cnt, 16'h0000);
    end
    rc(7'h1a, rx);
    chk(rx, 16'h0000);
    chk({15'h0, standby_out}, 16'h0001);
    $display("test quick commands done");
    // timed commands: exact suspend length, words refused meanwhile
    tn = '{8, 7, 6, 3, 1};
    for (int i = 0; i < 5; i++) begin
      wr(7'h46, 16'h0000);
      wr(7'h20, 16'h0011);
      last_pulse = 9'h000;
      susp_cnt = 16'h0000;
      if (tn[i] == 8)
        wb(7'h4b, 8'h01);
      else
        wb(7'h4a, 8'h01 << tn[i]);
      wb(7'h20, 8'h55);
      // a low clock enable freezes the countdown, so suspend lasts longer
      if (i == 1) begin
        ce_in <= 1'b0;
        tk(10);
        ce_in <= 1'b1;
      end
      for (int k = 0; k < 2000 && suspend_out === 1'b1; k++)
        tk(1);
      tk(2);
      chk(susp_cnt, 16'(tc[i] + ((i == 1) ? 10 : 0)));
      chk({7'h0, last_pulse}, 16'h0001 << tn[i]);
      chk({15'h0, standby_out}, 16'h0000);
      rc(7'h46, rx);
      chk(rx, (tn[i] == 7 || tn[i] == 1) ? 16'h0006 : 16'h0000);
      rc(7'h20, rx);
      chk(rx, (tn[i] == 7 || tn[i] == 1) ? 16'h0000 : 16'h0011);
    end
    $display("test timed commands done");
    give_verdict();
  end
endmodule

//--- hdl/scs_consts.svh
/*
  constants for the sensor command and status register group: clock rate,
  command times, register byte addresses, field positions, masks, defaults.
  assumes it is included by bare name before the package and the module.
*/
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_CLK_MHZ 100
`define SCS_WAKE_TIME_US 200
`define SCS_SWRST_TIME_MS 32
`define SCS_ERASE_TIME_MS 350
`define SCS_SAVE_TIME_MS 24
`define SCS_FACTORY_TIME_MS 350
`define SCS_WORD_BITS 16
`define SCS_ADDR_DIAG 7'h1a
`define SCS_ADDR_XOFF 7'h20
`define SCS_ADDR_YOFF 7'h22
`define SCS_ADDR_ZOFF 7'h24
`define SCS_ADDR_GPIO 7'h44
`define SCS_ADDR_MISC 7'h46
`define SCS_ADDR_CMD 7'h4a
`define SCS_CMD_WAKE 8
`define SCS_CMD_SWRST 7
`define SCS_CMD_ERASE 6
`define SCS_CMD_PEAKCLR 5
`define SCS_CMD_DIAGCLR 4
`define SCS_CMD_SAVE 3
`define SCS_CMD_STANDBY 2
`define SCS_CMD_FACTORY 1
`define SCS_CMD_AUTONULL 0
`define SCS_MISC_SUMSQ 15
`define SCS_MISC_PEAK 14
`define SCS_MISC_NOPOST 9
`define SCS_MISC_SELFTEST 8
`define SCS_MISC_DREN 2
`define SCS_MISC_DRPOL 1
`define SCS_MISC_DRSEL 0
`define SCS_GPIO_LVL 8
`define SCS_DIAG_UNDER 0
`define SCS_DIAG_OVER 1
`define SCS_DIAG_FLASH 2
`define SCS_DIAG_SPI 3
`define SCS_DIAG_POSTRUN 4
`define SCS_DIAG_POSTFAIL 5
`define SCS_DIAG_CKSUM 6
`define SCS_DIAG_BUFFULL 7
`define SCS_DIAG_ALM1 8
`define SCS_DIAG_ALM2 9
`define SCS_MISC_MASK 16'hc307
`define SCS_GPIO_MASK 16'h0303
`define SCS_OFF_MASK 16'h03ff
`define SCS_DIAG_MASK 16'h03ff
`define SCS_MISC_RESET 16'h0006
`endif

//--- hdl/scs_pkg.sv
/*
  types of the sensor command and status register group.
  assumes scs_consts.svh is on the include path.
*/
package scs_pkg;
  typedef enum logic [0:0] {SCS_IDLE, SCS_EXEC} scs_mode_t;
  // serial port sampling and shifting state
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic mosi_s1;
    logic mosi_s2;
    logic [3:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
  } scs_spi_t;
  // host visible registers
  typedef struct packed {
    logic [15:0] diag;
    logic [15:0] xoff;
    logic [15:0] yoff;
    logic [15:0] zoff;
    logic [15:0] gpio;
    logic [15:0] misc;
  } scs_regs_t;
  // whole module state
  typedef struct packed {
    scs_spi_t spi;
    scs_regs_t regs;
    scs_mode_t mode;
    logic [8:0] cmd;
    logic [8:0] cmd_pulse;
    logic [25:0] timer;
    logic standby;
    logic [1:0] dio_s1;
    logic [1:0] dio_s2;
    logic [1:0] dio_o;
    logic [1:0] dio_oe;
  } scs_state_t;
endpackage

//--- hdl/scs_regs.sv
/*
  serial slave, command executor and register group of the impact sensor.
  assumes a four-wire serial master (mode 3, 16-bit words) on the pins and
  same-clock sampling, alarm and self-test logic on the status inputs.
*/
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_regs
  import scs_pkg::*;
#(
  parameter logic [25:0] WAKE_CYC =
    26'(`SCS_WAKE_TIME_US * `SCS_CLK_MHZ),
  parameter logic [25:0] SWRST_CYC =
    26'(`SCS_SWRST_TIME_MS * 1000 * `SCS_CLK_MHZ),
  parameter logic [25:0] ERASE_CYC =
    26'(`SCS_ERASE_TIME_MS * 1000 * `SCS_CLK_MHZ),
  parameter logic [25:0] SAVE_CYC =
    26'(`SCS_SAVE_TIME_MS * 1000 * `SCS_CLK_MHZ),
  parameter logic [25:0] FACTORY_CYC =
    26'(`SCS_FACTORY_TIME_MS * 1000 * `SCS_CLK_MHZ)
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic dio_one_in,
  output logic dio_one_out,
  output logic dio_one_oe_out,
  input wire logic dio_two_in,
  output logic dio_two_out,
  output logic dio_two_oe_out,
  input wire logic data_ready_in,
  input wire logic [1:0] alarm_claim_in,
  input wire logic [1:0] alarm_level_in,
  input wire logic sample_tick_in,
  input wire logic supply_over_in,
  input wire logic supply_under_in,
  input wire logic checksum_bad_in,
  input wire logic alarm_one_in,
  input wire logic alarm_two_in,
  input wire logic buffer_full_in,
  input wire logic post_running_in,
  input wire logic post_fail_in,
  input wire logic flash_fail_in,
  output logic [8:0] command_pulse_out,
  output logic standby_out,
  output logic suspend_out,
  output logic peak_sum_en_out,
  output logic peak_axis_en_out,
  output logic skip_post_out,
  output logic self_test_out,
  output logic [9:0] x_offset_trim_out,
  output logic [9:0] y_offset_trim_out,
  output logic [9:0] z_offset_trim_out
);

  // merge one byte into a register word, masking unused bits
  function automatic logic [15:0] put_byte(input logic [15:0] old,
      input logic hi, input logic [7:0] b, input logic [15:0] mask);
    logic [15:0] w;
    w = hi ? {b, old[7:0]} : {old[15:8], b};
    return w & mask;
  endfunction

  // general line level as read back: pin level for inputs
  function automatic logic [15:0] gpio_view(input logic [15:0] g,
      input logic [1:0] pins);
    logic [15:0] v;
    v = g;
    for (int i = 0; i < 2; i++) begin
      if (!g[i]) begin
        v[`SCS_GPIO_LVL + i] = pins[i];
      end
    end
    return v & `SCS_GPIO_MASK;
  endfunction

  scs_state_t s; // registered state
  scs_state_t next_s; // next state
  logic sclk_rise; // edge of the synchronised serial clock
  logic sclk_fall;
  logic cs_rise; // end of a transfer
  logic cs_fall; // start of a transfer
  logic word_done; // 16th rising clock of a word seen
  logic diag_read; // host read of the status register
  logic start_timed; // a timed command starts this cycle
  logic [15:0] ev; // status events of this cycle

  // edge finding looks only at second and third sampling stages
  assign sclk_rise = s.spi.sclk_s2 & ~s.spi.sclk_d;
  assign sclk_fall = ~s.spi.sclk_s2 & s.spi.sclk_d;
  assign cs_rise = s.spi.cs_s2 & ~s.spi.cs_d;
  assign cs_fall = ~s.spi.cs_s2 & s.spi.cs_d;

  // next-state logic: serial port, decode, commands, status, lines
  always_comb begin
    logic [15:0] word;
    logic [6:0] waddr;
    logic hi;
    logic [8:0] cmd_new;
    logic dr_lvl;
    word = '0;
    waddr = '0;
    hi = 1'b0;
    cmd_new = '0;
    dr_lvl = 1'b0;
    next_s = s;
    word_done = 1'b0;
    diag_read = 1'b0;
    start_timed = 1'b0;
    ev = '0;
    next_s.cmd_pulse = '0;
    // two stage sampling of every pin
    next_s.spi.sclk_s1 = sclk_in;
    next_s.spi.sclk_s2 = s.spi.sclk_s1;
    next_s.spi.sclk_d = s.spi.sclk_s2;
    next_s.spi.cs_s1 = cs_n_in;
    next_s.spi.cs_s2 = s.spi.cs_s1;
    next_s.spi.cs_d = s.spi.cs_s2;
    next_s.spi.mosi_s1 = mosi_in;
    next_s.spi.mosi_s2 = s.spi.mosi_s1;
    next_s.dio_s1 = {dio_two_in, dio_one_in};
    next_s.dio_s2 = s.dio_s1;
    // a new transfer starts counting from zero, unless a rising clock is seen in the same cycle
    if (cs_fall) begin
      next_s.spi.bit_cnt = '0;
    end
    // shift in on rising clock
    if (!s.spi.cs_s2 && sclk_rise) begin
      next_s.spi.rx = {s.spi.rx[14:0], s.spi.mosi_s2};
      next_s.spi.bit_cnt = s.spi.bit_cnt + 4'h1;
      word_done = (s.spi.bit_cnt == 4'hf);
    end
    // shift out on falling clock; the first bit of a word is already out
    if (!s.spi.cs_s2 && sclk_fall && s.spi.bit_cnt != 4'h0) begin
      next_s.spi.tx = {s.spi.tx[14:0], 1'b0};
    end
    if (cs_rise && s.spi.bit_cnt != 4'h0) begin
      ev[`SCS_DIAG_SPI] = 1'b1;
    end
    ev[`SCS_DIAG_UNDER] = sample_tick_in & supply_under_in;
    ev[`SCS_DIAG_OVER] = sample_tick_in & supply_over_in;
    ev[`SCS_DIAG_ALM1] = alarm_one_in;
    ev[`SCS_DIAG_ALM2] = alarm_two_in;
    ev[`SCS_DIAG_BUFFULL] = buffer_full_in;
    ev[`SCS_DIAG_POSTRUN] = post_running_in;
    ev[`SCS_DIAG_POSTFAIL] = post_fail_in;
    ev[`SCS_DIAG_FLASH] = flash_fail_in;
    if (word_done && s.mode == SCS_IDLE) begin
      word = {s.spi.rx[14:0], s.spi.mosi_s2};
      waddr = {word[14:9], 1'b0};
      hi = word[8];
      if (!word[15]) begin
        // read: answer travels in the next word
        unique case (waddr)
          `SCS_ADDR_DIAG: begin
            next_s.spi.tx = s.regs.diag;
            diag_read = 1'b1;
          end
          `SCS_ADDR_XOFF: next_s.spi.tx = s.regs.xoff;
          `SCS_ADDR_YOFF: next_s.spi.tx = s.regs.yoff;
          `SCS_ADDR_ZOFF: next_s.spi.tx = s.regs.zoff;
          `SCS_ADDR_GPIO: next_s.spi.tx = gpio_view(s.regs.gpio, s.dio_s2);
          `SCS_ADDR_MISC: next_s.spi.tx = s.regs.misc;
          // unmapped and command reads give zero
          default: next_s.spi.tx = '0;
        endcase
      end else begin
        // masks drop writes to unused bits
        unique case (waddr)
          `SCS_ADDR_XOFF: next_s.regs.xoff =
            put_byte(s.regs.xoff, hi, word[7:0], `SCS_OFF_MASK);
          `SCS_ADDR_YOFF: next_s.regs.yoff =
            put_byte(s.regs.yoff, hi, word[7:0], `SCS_OFF_MASK);
          `SCS_ADDR_ZOFF: next_s.regs.zoff =
            put_byte(s.regs.zoff, hi, word[7:0], `SCS_OFF_MASK);
          `SCS_ADDR_GPIO: next_s.regs.gpio =
            put_byte(s.regs.gpio, hi, word[7:0], `SCS_GPIO_MASK);
          `SCS_ADDR_MISC: next_s.regs.misc =
            put_byte(s.regs.misc, hi, word[7:0], `SCS_MISC_MASK);
          `SCS_ADDR_CMD: cmd_new = hi ? {word[0], 8'h00} : {1'b0, word[7:0]};
          default: begin
          end
        endcase
      end
    end
    // commands act right after the 16th clock
    if (cmd_new != '0) begin
      next_s.cmd_pulse = cmd_new;
      if (cmd_new[`SCS_CMD_STANDBY]) begin
        next_s.standby = 1'b1;
      end
      if (cmd_new[`SCS_CMD_FACTORY] || cmd_new[`SCS_CMD_SWRST]) begin
        next_s.regs.xoff = '0;
        next_s.regs.yoff = '0;
        next_s.regs.zoff = '0;
        next_s.regs.gpio = '0;
        next_s.regs.misc = `SCS_MISC_RESET;
      end
      // one timed command at a time, highest bit first
      start_timed = 1'b1;
      if (cmd_new[`SCS_CMD_WAKE]) begin
        next_s.timer = WAKE_CYC;
      end else if (cmd_new[`SCS_CMD_SWRST]) begin
        next_s.timer = SWRST_CYC;
      end else if (cmd_new[`SCS_CMD_ERASE]) begin
        next_s.timer = ERASE_CYC;
      end else if (cmd_new[`SCS_CMD_SAVE]) begin
        next_s.timer = SAVE_CYC;
      end else if (cmd_new[`SCS_CMD_FACTORY]) begin
        next_s.timer = FACTORY_CYC;
      end else begin
        start_timed = 1'b0;
      end
      if (start_timed) begin
        next_s.mode = SCS_EXEC;
        next_s.cmd = cmd_new;
      end
    end
    // bit clears when its time is over
    if (s.mode == SCS_EXEC) begin
      if (s.timer <= 26'h1) begin
        next_s.mode = SCS_IDLE;
        next_s.cmd = '0;
        next_s.timer = '0;
        if (s.cmd[`SCS_CMD_WAKE]) begin
          next_s.standby = 1'b0;
        end
      end else begin
        next_s.timer = s.timer - 26'h1;
      end
    end
    // read or flag-clear command empties flags, events win
    if (diag_read || cmd_new[`SCS_CMD_DIAGCLR]) begin
      next_s.regs.diag = ev & `SCS_DIAG_MASK;
    end else begin
      next_s.regs.diag = (s.regs.diag | ev) & `SCS_DIAG_MASK;
    end
    next_s.regs.diag[`SCS_DIAG_CKSUM] = checksum_bad_in;
    dr_lvl = s.regs.misc[`SCS_MISC_DRPOL] ? data_ready_in : ~data_ready_in;
    for (int i = 0; i < 2; i++) begin
      if (s.regs.misc[`SCS_MISC_DREN] &&
          s.regs.misc[`SCS_MISC_DRSEL] == i[0]) begin
        next_s.dio_oe[i] = 1'b1;
        next_s.dio_o[i] = dr_lvl;
      end else if (alarm_claim_in[i]) begin
        next_s.dio_oe[i] = 1'b1;
        next_s.dio_o[i] = alarm_level_in[i];
      end else if (s.regs.gpio[i]) begin
        next_s.dio_oe[i] = 1'b1;
        next_s.dio_o[i] = s.regs.gpio[`SCS_GPIO_LVL + i];
      end else begin
        next_s.dio_oe[i] = 1'b0;
        next_s.dio_o[i] = 1'b0;
      end
    end
  end

  // state register; idle-high serial pins so reset makes no false edge
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.regs.misc <= `SCS_MISC_RESET;
      s.spi.sclk_s1 <= 1'b1;
      s.spi.sclk_s2 <= 1'b1;
      s.spi.sclk_d <= 1'b1;
      s.spi.cs_s1 <= 1'b1;
      s.spi.cs_s2 <= 1'b1;
      s.spi.cs_d <= 1'b1;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign miso_out = s.spi.tx[15];
  assign miso_oe_out = ~s.spi.cs_s2;
  assign dio_one_out = s.dio_o[0];
  assign dio_one_oe_out = s.dio_oe[0];
  assign dio_two_out = s.dio_o[1];
  assign dio_two_oe_out = s.dio_oe[1];
  assign command_pulse_out = s.cmd_pulse;
  assign standby_out = s.standby;
  // sampling held off while a command runs
  assign suspend_out = (s.mode == SCS_EXEC);
  assign peak_sum_en_out = s.regs.misc[`SCS_MISC_SUMSQ];
  assign peak_axis_en_out = s.regs.misc[`SCS_MISC_PEAK];
  assign skip_post_out = s.regs.misc[`SCS_MISC_NOPOST];
  assign self_test_out = s.regs.misc[`SCS_MISC_SELFTEST];
  assign x_offset_trim_out = s.regs.xoff[9:0];
  assign y_offset_trim_out = s.regs.yoff[9:0];
  assign z_offset_trim_out = s.regs.zoff[9:0];

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_CMD_BUSY: assert property (
    (ce_in && start_timed) |=> suspend_out && s.timer != '0)
    else $error("timed command did not suspend");
  AST_BUSY_HOLD: assert property (
    (ce_in && s.mode == SCS_EXEC && s.timer > 26'h1)
      |=> $stable(s.regs.misc) && $stable(s.regs.gpio))
    else $error("register changed while busy");
  AST_SELF_CLEAR: assert property (
    (ce_in && s.mode == SCS_EXEC && s.timer == 26'h1)
      |=> !suspend_out && s.cmd == '0)
    else $error("command bit did not clear");
  AST_STANDBY: assert property (
    command_pulse_out[`SCS_CMD_STANDBY] |-> standby_out)
    else $error("standby not entered");
  AST_WAKE: assert property (
    $fell(standby_out) |-> $past(s.cmd[`SCS_CMD_WAKE]) && !suspend_out)
    else $error("standby left without wake");
  AST_READ_CLEAR: assert property (
    (ce_in && diag_read && ev == '0 && !checksum_bad_in)
      |=> s.regs.diag == '0)
    else $error("status not cleared by read");
  AST_SPI_FAIL: assert property (
    (ce_in && cs_rise && s.spi.bit_cnt != 4'h0)
      |=> s.regs.diag[`SCS_DIAG_SPI])
    else $error("serial fail flag not set");
  AST_SUPPLY: assert property (
    (ce_in && sample_tick_in && supply_over_in)
      |=> s.regs.diag[`SCS_DIAG_OVER])
    else $error("over-voltage flag not set");
  AST_DR_WINS: assert property (
    (ce_in && s.regs.misc[`SCS_MISC_DREN] && !s.regs.misc[`SCS_MISC_DRSEL])
      |=> dio_one_oe_out && dio_one_out ==
        ($past(s.regs.misc[`SCS_MISC_DRPOL]) ~^ $past(data_ready_in)))
    else $error("data-ready lost line one");
  AST_GPIO: assert property (
    (ce_in && !s.regs.misc[`SCS_MISC_DREN] && !alarm_claim_in[1] &&
      s.regs.gpio[1]) |=> dio_two_oe_out &&
      dio_two_out == $past(s.regs.gpio[`SCS_GPIO_LVL + 1]))
    else $error("general line two not driven");

endmodule
